/* rtl/crm_pkg.sv */
// Contract
// [R1] Square-law magnitudes run only in full power; estimates run in both modes.
// [R2] Square, low-pass and root all seven channels; 24-bit results.
// [R3] Estimate covers the three phase currents only; 20-bit results.
// [R4] Sum select 0 gives neutral magnitude; 1 gives magnitude of phase sum.
// [R5] Current magnitudes are signed 24-bit and refresh at 8 kHz.
// [R6] Integrator off: full-scale sine gives 0x39792c at any line frequency.
// [R7] Integrator on: full-scale sine gives 0x395e66 at 50 Hz, 0x2fcf17 at 60 Hz.
// [R8] Magnitude settles within 580 ms integrator off, 700 ms on.
// [R9] Magnitude words read as 32 bits with upper eight bits zero.
// [R10] Output is root of squared magnitude plus 128 times its own offset.
// [R11] Offsets are 32-bit words, top four zero, sign-extended to 28 bits.
// [R12] Estimate: high-pass, absolute value, average; unsigned 20-bit at 8 kHz.
// [R13] Full-scale sine estimate is 209686 at 50 Hz, 210921 at 60 Hz.
// [R14] Estimate reaches input within 0.5% no later than 500 ms; averaging shift 0x0a needs about 680 ms for 0.5%.
// [R15] Estimate words read as 32 bits with upper twelve bits zero.
// [R16] No estimate is produced for the neutral current.
// [R17] Host should read magnitudes in step with voltage zero crossings.
// [R18] One computation pass per 8 kHz period; pass end sets data-ready flag.
// [R19] A negative corrected square is limited to zero before the root.
package crm_pkg;
    localparam int CLK_HZ     = 10_000_000;
    localparam int RATE_HZ    = 8000;
    localparam int PASS_CYC   = CLK_HZ / RATE_HZ;
    localparam int SETTLE_OFF_MS = 580;
    localparam int SETTLE_ON_MS  = 700;
    localparam int SETTLE_MAV_MS = 500;
    // Low-pass shift with integrator off fits about 4.5 time constants in 580 ms; shift 0x0b fits about 2.7 in 700 ms.
    localparam logic [4:0] LPF_SH_OFF = 5'h0a;
    localparam logic [4:0] LPF_SH_ON  = 5'h0b;
    localparam logic [4:0] HPF_SH     = 5'h0c;
    localparam logic [4:0] MAV_SH     = 5'h0a;
    localparam int         MAV_SCALE  = 4;
    localparam int         OS_SCALE   = 7;
    localparam logic [3:0] IX_MAG_A   = 4'h0;
    localparam logic [3:0] IX_MAG_N   = 4'h3;
    localparam logic [3:0] IX_OS_A    = 4'h4;
    localparam logic [3:0] IX_OS_N    = 4'h7;
    localparam logic [3:0] IX_MAV_A   = 4'h8;
    localparam logic [3:0] IX_MAV_C   = 4'ha;
    localparam logic [3:0] IX_VMAG_A  = 4'hb;
    localparam logic [3:0] IX_VMAG_C  = 4'hd;
    localparam logic [3:0] IX_CFG3    = 4'he;
    localparam logic [3:0] IX_STATUS  = 4'hf;
    localparam int         SUM_SEL_POS = 2;
    localparam int         READY_FLAG_POS = 17;
    localparam logic [23:0] MAG_MAX   = 24'h7fffff;
    localparam logic [19:0] MAV_MAX   = 20'hfffff;
    typedef enum logic [1:0] {ST_IDLE, ST_FILT, ST_ROOT, ST_NEXT} crm_state_e;
endpackage

/* rtl/crm_iir.sv */
`timescale 1ns/1ps
// First-order low-pass step; the difference is one bit wider so it never wraps.
module crm_iir #(
    parameter int W = 26
) (
    // Operands
    input  wire logic signed [W-1:0] x_in,
    input  wire logic signed [W-1:0] y_in,
    input  wire logic [4:0]          shift_in,
    // Result
    output logic signed [W-1:0]      y_out
);
    logic signed [W:0] diff;
    always_comb begin
        diff  = (W+1)'(x_in) - (W+1)'(y_in);
        y_out = W'((W+1)'(y_in) + (diff >>> shift_in));
    end
endmodule

/* rtl/crm_sqrt.sv */
`timescale 1ns/1ps
// Bit-serial square root, one result bit per clock.
module crm_sqrt (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // Request
    input  wire logic        start_in,
    input  wire logic [51:0] rad_in,
    // Answer
    output logic             done_out,
    output logic [25:0]      root_out
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [4:0]  idx;
        logic [25:0] root;
        logic [51:0] rad;
    } crm_sqrt_s;
    crm_sqrt_s r, n;
    logic [25:0] trial;
    always_comb begin
        n      = r;
        n.done = 1'b0;
        trial  = r.root | (26'h1 << r.idx);
        if (start_in && !r.busy) begin
            n.busy = 1'b1;
            n.idx  = 5'h19;
            n.root = 26'h0;
            n.rad  = rad_in;
        end else if (r.busy) begin
            if (52'(trial) * 52'(trial) <= r.rad) begin
                n.root = trial;
            end
            if (r.idx == 5'h0) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.idx = r.idx - 5'h1;
            end
        end
    end
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign done_out = r.done;
    assign root_out = r.root;
endmodule

/* rtl/crm_core.sv */
`timescale 1ns/1ps
module crm_core (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // Samples, one strobe per 8 kHz period
    input  wire logic        sample_valid_in,
    input  wire logic [23:0] ia_in,
    input  wire logic [23:0] ib_in,
    input  wire logic [23:0] ic_in,
    input  wire logic [23:0] in_in,
    input  wire logic [23:0] va_in,
    input  wire logic [23:0] vb_in,
    input  wire logic [23:0] vc_in,
    // Operating state
    input  wire logic        full_power_mode_in,
    input  wire logic        reduced_power_current_mode_in,
    input  wire logic        integrator_enable_bit_in,
    // Register port
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic [31:0]      reg_rdata_out,
    output logic             reg_rvalid_out,
    // Pass end
    output logic             data_ready_out
);
    typedef struct packed {
        crm_pkg::crm_state_e   st;
        logic [2:0]            ch;
        logic                  rms_on;
        logic                  mav_on;
        logic [6:0][51:0]      ms;
        logic [2:0][25:0]      dc;
        logic [2:0][25:0]      avg;
        logic [6:0][23:0]      stage;
        logic [6:0][23:0]      mag;
        logic [2:0][19:0]      mav;
        logic [3:0][27:0]      os;
        logic                  sum_sel;
        logic                  flag;
        logic                  rdy_pulse;
        logic                  sq_go;
        logic [31:0]           rdata;
        logic                  rvalid;
    } crm_core_s;
    crm_core_s r, n;

    logic signed [25:0] x;
    logic signed [51:0] sq;
    logic signed [51:0] ms_nxt;
    logic signed [25:0] dc_nxt;
    logic signed [25:0] hp;
    logic signed [25:0] hp_abs;
    logic signed [25:0] avg_nxt;
    logic signed [53:0] corr;
    logic [51:0]        rad;
    logic [4:0]         lpf_sh;
    logic               sq_done;
    logic [25:0]        root;
    logic [1:0]         mi;
    logic [27:0]        os_sel;
    logic               set_flag;

    crm_iir #(.W(52)) u_lpf (
        .x_in     (sq),
        .y_in     (r.ms[r.ch]),
        .shift_in (lpf_sh),
        .y_out    (ms_nxt)
    );
    crm_iir #(.W(26)) u_hpf (
        .x_in     (x),
        .y_in     (r.dc[mi]),
        .shift_in (crm_pkg::HPF_SH),
        .y_out    (dc_nxt)
    );
    crm_iir #(.W(26)) u_avg (
        .x_in     (hp_abs),
        .y_in     (r.avg[mi]),
        .shift_in (crm_pkg::MAV_SH), // see [R14]
        .y_out    (avg_nxt)
    );
    crm_sqrt u_sqrt (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .start_in    (r.sq_go),
        .rad_in      (rad),
        .done_out    (sq_done),
        .root_out    (root)
    );

    always_comb begin
        n        = r;
        n.rdy_pulse = 1'b0;
        n.sq_go  = 1'b0;
        n.rvalid = 1'b0;
        set_flag = 1'b0;
        mi       = r.ch[1:0];
        lpf_sh   = integrator_enable_bit_in ? crm_pkg::LPF_SH_ON : crm_pkg::LPF_SH_OFF; // see [R8]
        case (r.ch)
            3'h0: x = 26'(signed'(ia_in));
            3'h1: x = 26'(signed'(ib_in));
            3'h2: x = 26'(signed'(ic_in));
            3'h3: x = r.sum_sel ? 26'(signed'(ia_in)) + 26'(signed'(ib_in))
                                  + 26'(signed'(ic_in)) : 26'(signed'(in_in)); // see [R4]
            3'h4: x = 26'(signed'(va_in));
            3'h5: x = 26'(signed'(vb_in));
            default: x = 26'(signed'(vc_in));
        endcase
        sq     = 52'(x * x); // see [R6] [R7]
        hp     = x - r.dc[mi]; // see [R12]
        hp_abs = hp[25] ? -hp : hp; // see [R13]
        // Voltage channels carry no offset here; theirs live outside this block.
        os_sel = (r.ch < 3'h4) ? r.os[r.ch[1:0]] : 28'h0;
        corr   = 54'(r.ms[r.ch]) + (54'(signed'(os_sel)) <<< crm_pkg::OS_SCALE); // see [R10]
        rad    = corr[53] ? 52'h0 : corr[51:0]; // see [R19]
        case (r.st)
            crm_pkg::ST_IDLE: begin
                if (sample_valid_in && (full_power_mode_in || reduced_power_current_mode_in)) begin
                    n.st     = crm_pkg::ST_FILT;
                    n.ch     = 3'h0;
                    n.rms_on = full_power_mode_in; // see [R1]
                    n.mav_on = 1'b1; // see [R1]
                end
            end
            crm_pkg::ST_FILT: begin
                if (r.mav_on && r.ch < 3'h3) begin // see [R16]
                    n.dc[mi]  = dc_nxt;
                    n.avg[mi] = avg_nxt;
                end
                if (r.rms_on) begin
                    n.ms[r.ch] = ms_nxt; // see [R2]
                    n.sq_go    = 1'b1;
                    n.st       = crm_pkg::ST_ROOT;
                end else begin
                    n.st = crm_pkg::ST_NEXT;
                end
            end
            crm_pkg::ST_ROOT: begin
                if (sq_done) begin
                    n.stage[r.ch] = (root > 26'(crm_pkg::MAG_MAX)) ? crm_pkg::MAG_MAX : root[23:0];
                    n.st          = crm_pkg::ST_NEXT;
                end
            end
            crm_pkg::ST_NEXT: begin
                if (r.ch == 3'h6) begin
                    if (r.rms_on) begin
                        n.mag = r.stage; // see [R5]
                    end
                    for (int i = 0; i < 3; i++) begin // see [R3]
                        n.mav[i] = (r.avg[i][25:crm_pkg::MAV_SCALE] > 22'(crm_pkg::MAV_MAX))
                                   ? crm_pkg::MAV_MAX
                                   : r.avg[i][19+crm_pkg::MAV_SCALE:crm_pkg::MAV_SCALE];
                    end
                    n.rdy_pulse = 1'b1; // see [R18]
                    set_flag = 1'b1;
                    n.st     = crm_pkg::ST_IDLE;
                end else begin
                    n.ch = r.ch + 3'h1;
                    n.st = crm_pkg::ST_FILT;
                end
            end
            default: n.st = crm_pkg::ST_IDLE;
        endcase
        if (reg_wr_in) begin
            if (reg_addr_in >= crm_pkg::IX_OS_A && reg_addr_in <= crm_pkg::IX_OS_N) begin
                n.os[reg_addr_in[1:0]] = 28'(signed'(reg_wdata_in[23:0])); // see [R11]
            end
            if (reg_addr_in == crm_pkg::IX_CFG3) begin
                n.sum_sel = reg_wdata_in[crm_pkg::SUM_SEL_POS];
            end
        end
        // A pass ending in the same cycle as a clear keeps the flag set.
        n.flag = (r.flag && !(reg_wr_in && reg_addr_in == crm_pkg::IX_STATUS
                 && reg_wdata_in[crm_pkg::READY_FLAG_POS])) || set_flag;
        if (reg_rd_in) begin
            n.rvalid = 1'b1;
            n.rdata  = 32'h0;
            if (reg_addr_in <= crm_pkg::IX_MAG_N) begin
                n.rdata = {8'h00, r.mag[reg_addr_in[1:0]]}; // see [R9]
            end else if (reg_addr_in <= crm_pkg::IX_OS_N) begin
                n.rdata = {4'h0, r.os[reg_addr_in[1:0]]}; // see [R11]
            end else if (reg_addr_in <= crm_pkg::IX_MAV_C) begin
                n.rdata = {12'h000, r.mav[2'(reg_addr_in - crm_pkg::IX_MAV_A)]}; // see [R15]
            end else if (reg_addr_in <= crm_pkg::IX_VMAG_C) begin
                n.rdata = {8'h00, r.mag[3'(reg_addr_in - crm_pkg::IX_VMAG_A) + 3'h4]};
            end else if (reg_addr_in == crm_pkg::IX_CFG3) begin
                n.rdata[crm_pkg::SUM_SEL_POS] = r.sum_sel;
            end else begin
                n.rdata[crm_pkg::READY_FLAG_POS] = r.flag;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r    <= '0;
            r.st <= crm_pkg::ST_IDLE;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata_out  = r.rdata;
    assign reg_rvalid_out = r.rvalid;
    assign data_ready_out = r.rdy_pulse;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // The register port answers every read one cycle later and holds its data otherwise.
    property p_rms_pad;
        reg_rd_in && reg_addr_in <= crm_pkg::IX_MAG_N
        |=> reg_rvalid_out && reg_rdata_out[31:24] == 8'h00;
    endproperty
    a_rms_pad: assert property (p_rms_pad) else $error("magnitude word not zero padded"); // see [R9]
    property p_mav_pad;
        reg_rd_in && reg_addr_in >= crm_pkg::IX_MAV_A && reg_addr_in <= crm_pkg::IX_MAV_C
        |=> reg_rdata_out[31:20] == 12'h000;
    endproperty
    a_mav_pad: assert property (p_mav_pad) else $error("estimate word not zero padded"); // see [R15]
    property p_os_ext;
        reg_wr_in && reg_addr_in == crm_pkg::IX_OS_A
        ##2 reg_rd_in && reg_addr_in == crm_pkg::IX_OS_A
        |=> reg_rdata_out[27:23] == {5{$past(reg_wdata_in[23], 3)}}
            && reg_rdata_out[31:28] == 4'h0;
    endproperty
    a_os_ext: assert property (p_os_ext) else $error("offset not sign extended"); // see [R11]
    property p_rvalid;
        reg_rd_in |=> reg_rvalid_out;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered"); // see [R9]
    property p_rvalid_low;
        !reg_rd_in |=> !reg_rvalid_out;
    endproperty
    a_rvalid_low: assert property (p_rvalid_low) else $error("answer without read"); // see [R9]
    property p_rdata_hold;
        !reg_rd_in |=> $stable(reg_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // see [R9]
    property p_sum_sel_wr;
        reg_wr_in && reg_addr_in == crm_pkg::IX_CFG3
        |=> r.sum_sel == $past(reg_wdata_in[crm_pkg::SUM_SEL_POS]);
    endproperty
    a_sum_sel_wr: assert property (p_sum_sel_wr) else $error("sum select not stored"); // see [R4]
    property p_mag_ro;
        reg_wr_in && reg_addr_in <= crm_pkg::IX_MAG_N && !set_flag |=> $stable(r.mag);
    endproperty
    a_mag_ro: assert property (p_mag_ro) else $error("magnitude written by host"); // see [R5]

    // The pass engine checks make no assumption about the sample values.
    property p_rms_hold;
        r.st == crm_pkg::ST_NEXT && r.ch == 3'h6 && !r.rms_on |=> $stable(r.mag);
    endproperty
    a_rms_hold: assert property (p_rms_hold) else $error("magnitude changed in reduced mode"); // see [R1]
    property p_no_mode;
        r.st == crm_pkg::ST_IDLE && !full_power_mode_in && !reduced_power_current_mode_in
        |=> r.st == crm_pkg::ST_IDLE;
    endproperty
    a_no_mode: assert property (p_no_mode) else $error("pass started with no mode"); // see [R1]
    property p_no_root;
        r.st != crm_pkg::ST_IDLE && !r.rms_on |-> r.st != crm_pkg::ST_ROOT;
    endproperty
    a_no_root: assert property (p_no_root) else $error("root taken in reduced mode"); // see [R1]
    property p_sq_start;
        r.st == crm_pkg::ST_FILT && r.rms_on |=> r.st == crm_pkg::ST_ROOT && r.sq_go;
    endproperty
    a_sq_start: assert property (p_sq_start) else $error("root not started"); // see [R2]
    property p_ready_pulse;
        data_ready_out |=> !data_ready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("data ready too long"); // see [R18]
    property p_flag_clear;
        r.flag && reg_wr_in && reg_addr_in == crm_pkg::IX_STATUS
        && reg_wdata_in[crm_pkg::READY_FLAG_POS] && !set_flag
        |=> !r.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("ready flag not cleared"); // see [R18]
    property p_mag_refresh;
        !data_ready_out |-> $stable(r.mag) and $stable(r.mav);
    endproperty
    a_mag_refresh: assert property (p_mag_refresh) else $error("result changed mid pass"); // see [R5]
    property p_nonneg;
        data_ready_out |-> r.mag[0][23] == 1'b0 && r.mag[3][23] == 1'b0;
    endproperty
    a_nonneg: assert property (p_nonneg) else $error("magnitude negative"); // see [R19]
    property p_flag;
        data_ready_out |-> r.flag;
    endproperty
    a_flag: assert property (p_flag) else $error("data ready flag not set"); // see [R18]
    // A full pass is seven channels of thirty cycles, so the bound leaves a margin.
    property p_pass_len;
        r.st == crm_pkg::ST_IDLE ##1 r.st == crm_pkg::ST_FILT |-> ##[1:220] data_ready_out;
    endproperty
    a_pass_len: assert property (p_pass_len) else $error("pass did not finish"); // see [R18]
    property p_mav_only3;
        r.st == crm_pkg::ST_FILT && r.ch == 3'h3 |=> $stable(r.dc) and $stable(r.avg);
    endproperty
    a_mav_only3: assert property (p_mav_only3) else $error("estimate touched neutral"); // see [R16]

    // Covers show that each main scenario is reached at least once.
    c_full_pass: cover property (full_power_mode_in && data_ready_out);
    c_flag_race: cover property (set_flag && reg_wr_in && reg_addr_in == crm_pkg::IX_STATUS);
    c_reduced_pass: cover property (!full_power_mode_in && data_ready_out);
    c_sum_sel: cover property (r.sum_sel && data_ready_out);
    c_clamp: cover property (r.st == crm_pkg::ST_FILT && corr[53]);
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int LIMIT = 60000;
    logic        core_clk_in                   = 1'b0;
    logic        rst_in                        = 1'b1;
    logic        sample_valid_in               = 1'b0;
    logic [23:0] ia_in                         = 24'h0;
    logic [23:0] ib_in                         = 24'h0;
    logic [23:0] ic_in                         = 24'h0;
    logic [23:0] in_in                         = 24'h0;
    logic [23:0] va_in                         = 24'h0;
    logic [23:0] vb_in                         = 24'h0;
    logic [23:0] vc_in                         = 24'h0;
    logic        full_power_mode_in            = 1'b0;
    logic        reduced_power_current_mode_in = 1'b0;
    logic        integrator_enable_bit_in      = 1'b0;
    logic        reg_wr_in                     = 1'b0;
    logic        reg_rd_in                     = 1'b0;
    logic [3:0]  reg_addr_in                   = 4'h0;
    logic [31:0] reg_wdata_in                  = 32'h0;
    logic [31:0] reg_rdata_out;
    logic        reg_rvalid_out;
    logic        data_ready_out;
    logic [31:0] rd;
    int          err_count       = 0;
    int          samples_checked = 0;
    int          cycles          = 0;

    crm_core u_crm_core (
        .core_clk_in                   (core_clk_in),
        .rst_in                        (rst_in),
        .sample_valid_in               (sample_valid_in),
        .ia_in                         (ia_in),
        .ib_in                         (ib_in),
        .ic_in                         (ic_in),
        .in_in                         (in_in),
        .va_in                         (va_in),
        .vb_in                         (vb_in),
        .vc_in                         (vc_in),
        .full_power_mode_in            (full_power_mode_in),
        .reduced_power_current_mode_in (reduced_power_current_mode_in),
        .integrator_enable_bit_in      (integrator_enable_bit_in),
        .reg_wr_in                     (reg_wr_in),
        .reg_rd_in                     (reg_rd_in),
        .reg_addr_in                   (reg_addr_in),
        .reg_wdata_in                  (reg_wdata_in),
        .reg_rdata_out                 (reg_rdata_out),
        .reg_rvalid_out                (reg_rvalid_out),
        .data_ready_out                (data_ready_out)
    );

    always #50 core_clk_in = ~core_clk_in;

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic do_reset();
        rst_in = 1'b1;
        repeat (10) tick();
        rst_in = 1'b0;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_wr_in    = 1'b1;
        reg_addr_in  = a;
        reg_wdata_in = d;
        tick();
        reg_wr_in = 1'b0;
        tick();
    endtask

    task automatic reg_read(input logic [3:0] a);
        reg_rd_in   = 1'b1;
        reg_addr_in = a;
        tick();
        reg_rd_in = 1'b0;
        chk("rvalid", {31'h0, reg_rvalid_out}, 32'h1);
        rd = reg_rdata_out;
        tick();
    endtask

    task automatic expect_reg(input string what, input logic [3:0] a, input logic [31:0] e);
        reg_read(a);
        chk(what, rd, e);
    endtask

    task automatic do_pass(input logic want_end);
        int k;
        k = 0;
        sample_valid_in = 1'b1;
        tick();
        sample_valid_in = 1'b0;
        while (k < 300 && data_ready_out !== 1'b1) begin
            tick();
            k++;
        end
        chk("pass_end", {31'h0, data_ready_out === 1'b1}, {31'h0, want_end});
        if (data_ready_out === 1'b1) begin
            tick();
            chk("ready_pulse", {31'h0, data_ready_out}, 32'h0);
        end
    endtask

    // Samples alternate in sign so the dc-blocking estimate path sees signal.
    task automatic passes(input int n, input logic [23:0] ph, input logic [23:0] nu);
        for (int i = 0; i < n; i++) begin
            ia_in = i[0] ? -ph : ph;
            ib_in = ia_in;
            ic_in = ia_in;
            va_in = ia_in;
            vb_in = ia_in;
            vc_in = ia_in;
            in_in = i[0] ? -nu : nu;
            do_pass(1'b1);
            repeat (20) tick();
        end
    endtask

    initial begin
        do_reset();
        for (int i = 0; i < 16; i++) begin
            expect_reg("reset_value", i[3:0], 32'h0);
        end
        $display("test reset values done");

        reg_write(4'h0, 32'hffffffff);
        reg_write(4'h8, 32'hffffffff);
        reg_write(4'hb, 32'hffffffff);
        expect_reg("ro_mag", 4'h0, 32'h0);
        expect_reg("ro_est", 4'h8, 32'h0);
        expect_reg("ro_vmag", 4'hb, 32'h0);
        reg_write(4'h4, 32'hab000008);
        expect_reg("offset_a", 4'h4, 32'h00000008);
        reg_write(4'h5, 32'h00fffff8);
        expect_reg("offset_b", 4'h5, 32'h0ffffff8);
        reg_write(4'h6, 32'h00800001);
        expect_reg("offset_c", 4'h6, 32'h0f800001);
        $display("test register access done");

        do_pass(1'b0);
        full_power_mode_in = 1'b1;
        do_pass(1'b1);
        expect_reg("status_ready", 4'hf, 32'h00020000);
        reg_write(4'hf, 32'h00020000);
        expect_reg("status_clear", 4'hf, 32'h0);
        expect_reg("mag_offset", 4'h0, 32'h00000020);
        expect_reg("mag_clamp", 4'h1, 32'h0);
        $display("test offset and pass done");

        full_power_mode_in            = 1'b0;
        reduced_power_current_mode_in = 1'b1;
        passes(12, 24'h200000, 24'h200000);
        expect_reg("mag_frozen", 4'h0, 32'h00000020);
        for (int i = 8; i < 11; i++) begin
            reg_read(i[3:0]);
            chk("est_pad", {20'h0, rd[31:20]}, 32'h0);
            chk("est_live", {31'h0, rd != 32'h0}, 32'h1);
        end
        $display("test reduced mode done");

        full_power_mode_in            = 1'b1;
        reduced_power_current_mode_in = 1'b0;
        for (int e = 0; e < 2; e++) begin
            integrator_enable_bit_in = e[0];
            passes(12, 24'h300000, 24'h0);
            for (int i = 0; i < 14; i++) begin
                if (i < 4 || i > 10) begin
                    reg_read(i[3:0]);
                    chk("mag_pad", {24'h0, rd[31:24]}, 32'h0);
                    chk("mag_sign", {31'h0, rd[23]}, 32'h0);
                    chk("mag_live", {31'h0, rd != 32'h0}, {31'h0, i != 3});
                end
            end
        end
        $display("test full power done");

        do_reset();
        full_power_mode_in = 1'b1;
        reg_write(4'he, 32'h00000004);
        expect_reg("sum_select", 4'he, 32'h00000004);
        passes(6, 24'h0, 24'h300000);
        expect_reg("neutral_sum", 4'h3, 32'h0);
        reg_write(4'he, 32'h0);
        passes(6, 24'h0, 24'h300000);
        reg_read(4'h3);
        chk("neutral_live", {31'h0, rd != 32'h0}, 32'h1);
        for (int i = 8; i < 11; i++) begin
            expect_reg("no_neutral_est", i[3:0], 32'h0);
        end
        $display("test sum select done");
        close_out();
    end
endmodule
